// *** logic/dsc_cfg.svh ***
// Deep sleep controller constants: register offsets, field positions,
// reset values and timing counts.
// Assumes a 12-bit register address and 8-bit register data.
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH

`define DSC_ADDR_W 12
`define DSC_DATA_W 8

// Register offsets
`define DSC_OFS_WAKE_LO 12'hf4a
`define DSC_OFS_WAKE_HI 12'hf4b
`define DSC_OFS_CTRL_LO 12'hf4c
`define DSC_OFS_CTRL_HI 12'hf4d
`define DSC_OFS_SCRATCH 12'hf4e
`define DSC_OFS_EXIT 12'hf50
`define DSC_OFS_CONFIG 12'hf51

// Control high fields
`define DSC_HI_DEEP_SLEEP_ENABLE 7
`define DSC_HI_ULP_MOD_EN 1
`define DSC_HI_CAL_WAKE_DIS 0
// Control low fields
`define DSC_LO_ULP_DIS 2
`define DSC_LO_BOR_EVT 1
`define DSC_LO_RELEASE 0
// Wake status low fields
`define DSC_WK_FAULT 7
`define DSC_WK_ULP 5
`define DSC_WK_WDT 4
`define DSC_WK_CAL 3
`define DSC_WK_POR 0
// Wake status high field
`define DSC_WK_INT0 0
// Exit status field
`define DSC_EXIT_FLAG 3

// Reset values
`define DSC_RST_BYTE 8'h00
`define DSC_CFG_RESET 8'h00

// Deep sleep enable lifetime in instruction cycles
`define DSC_DEEP_SLEEP_ENABLE_LIFE 2'h2

// Watchdog period is 2^(BASE + STEP * postscale) oscillator ticks
`define DSC_WDT_EXP_BASE 6
`define DSC_WDT_EXP_STEP 2
`define DSC_WDT_CNT_W 36

// Power-on reset hold after a wake
`define DSC_CLK_PERIOD_NS 50
`define DSC_POR_HOLD_NS 1000
`define DSC_POR_CYCLES ((`DSC_POR_HOLD_NS + `DSC_CLK_PERIOD_NS - 1) / `DSC_CLK_PERIOD_NS)

`endif

// *** logic/dsc_pkg.sv ***
// Deep sleep controller types.
// Assumes dsc_cfg.svh supplies all numeric constants.
package dsc_pkg;

  typedef enum logic [1:0] {
    DSC_ST_RUN,
    DSC_ST_DEEP,
    DSC_ST_POR
  } dsc_state_t;

  // Inputs that arrive from outside the sys_clk domain
  typedef struct packed {
    logic rc_tick;
    logic sosc_tick;
    logic cal_alarm;
    logic ulp_wake;
    logic int0_wake;
    logic fault;
    logic bor_arm;
    logic bor_trip;
    logic core_bor;
  } dsc_async_t;

  // Configuration byte, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] wdt_postscale;
    logic cal_clk_sel;
    logic bor_en;
    logic wdt_clk_sel;
    logic wdt_en;
  } dsc_config_t;

endpackage

// *** logic/dsc_wdt.sv ***
// Sleep watchdog: postscaled tick counter with selectable tick source.
// Assumes tick inputs are one-cycle pulses already in the sys_clk domain.
`timescale 1ns/10ps
`include "dsc_cfg.svh"

module dsc_wdt #(
  parameter int CNT_W = `DSC_WDT_CNT_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic run,
  input wire logic clk_sel,
  input wire logic [3:0] postscale,
  // Ticks
  input wire logic rc_tick,
  input wire logic sosc_tick,
  // Result
  output logic expire
);

  logic [CNT_W-1:0] count_r;
  logic expire_r;
  wire tick = clk_sel ? sosc_tick : rc_tick; // [R2]
  wire [CNT_W-1:0] top = period_top(postscale);

  // Terminal count for a postscale code
  function automatic logic [CNT_W-1:0] period_top(input logic [3:0] ps);
    int e;
    e = `DSC_WDT_EXP_BASE + `DSC_WDT_EXP_STEP * int'(ps);
    return {CNT_W{1'b1}} >> (CNT_W - e); // [R1]
  endfunction

  always_ff @(posedge sys_clk) begin
    expire_r <= 1'b0;
    if (reset || clear) begin
      count_r <= '0; // [R4]
    end else if (run && tick) begin // [R26]
      if (count_r == top) begin
        count_r <= '0;
        expire_r <= 1'b1;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end
  end

  assign expire = expire_r;

  a_wdt_clear_zero: assert property (@(posedge sys_clk) disable iff (reset)
    clear |=> count_r == '0 && !expire_r) else $error("watchdog not cleared"); // [R4]
  a_wdt_hold_idle: assert property (@(posedge sys_clk) disable iff (reset)
    !run && !clear |=> $stable(count_r)) else $error("watchdog ran while idle"); // [R26]

endmodule

// *** logic/dsc_pin_hold.sv ***
// Pin state hold: freezes pin direction and level until released.
// Assumes dir and lat come from core logic on sys_clk; dir high means input.
`timescale 1ns/10ps

module dsc_pin_hold #(
  parameter int PIN_W = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Control
  input wire logic capture,
  input wire logic hold,
  // Live pin settings
  input wire logic [PIN_W-1:0] dir,
  input wire logic [PIN_W-1:0] lat,
  // Pin drive
  output logic [PIN_W-1:0] pin_out,
  output logic [PIN_W-1:0] pin_oe
);

  logic [PIN_W-1:0] held_dir_r;
  logic [PIN_W-1:0] held_lat_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      held_dir_r <= '1;
      held_lat_r <= '0;
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      if (capture) begin
        held_dir_r <= dir;
        held_lat_r <= lat;
      end
      pin_out <= hold ? held_lat_r : lat; // [R21]
      pin_oe <= hold ? ~held_dir_r : ~dir;
    end
  end

  a_pin_hold_freeze: assert property (@(posedge sys_clk) disable iff (reset)
    hold |=> pin_out == $past(held_lat_r) && pin_oe == ~$past(held_dir_r))
    else $error("held pins moved"); // [R21]

endmodule

// *** logic/dsc_top.sv ***
// Deep sleep controller: entry sequence, wake gating and status,
// pin hold, persistent scratch byte and power-on reset after wake.
// Assumes one 20 MHz sys_clk; oscillator ticks and wake sources are async.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "dsc_cfg.svh"

// Operation
// R1: Watchdog postscaler spans 2.1 ms to 25.7 days
// R2: Watchdog ticks from RC or secondary oscillator
// R3: Software enables crystal oscillator before deep sleep
// R4: Watchdog enabled by config, cleared on entry
// R5: Brown-out monitor runs only when enabled
// R6: Calendar runs through sleep, alarm may wake
// R7: Calendar reference chosen by config select bit
// R8: Software sets regulator-off, clears idle before entry
// R9: Software waits calendar sync clear before entry
// R10: Enable bit and sleep issued back to back
// R11: Every wake performs power-on reset, reset vector
// R12: Exit flag set on wake, software clears it
// R13: Fault in deep sleep sets flag, wakes
// R14: Fault monitoring always on, no configuration
// R15: Enable bit picks deep or ordinary sleep
// R16: High bits 6..3 read zero, bit2 write zero
// R17: Module enable powers low-power wake during sleep
// R18: Calendar wake disable bit blocks alarm wake
// R19: Low-power wake needs disable clear, module enabled
// R20: Brown-out armed-not-tripped status bit
// R21: Pins held after wake until release cleared; a brown-out trip wake frees them at once
// R22: Scratch byte survives sleep, lost on brown-out
// R23: Enable bit self-clears two cycles after set
// R24: Entry clears both wake status registers
// R25: Only first wake source is recorded
// R26: Watchdog counts in deep sleep, wakes on expiry
module dsc_top #(
  parameter int PIN_W = 8,
  parameter int POR_CYCLES = `DSC_POR_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [`DSC_ADDR_W-1:0] reg_addr,
  input wire logic [`DSC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DSC_DATA_W-1:0] reg_rdata,
  // Core side
  input wire logic sleep_cmd,
  input wire logic regulator_off_in_sleep,
  input wire logic idle_on_sleep_select,
  input wire logic [PIN_W-1:0] pin_direction_register,
  input wire logic [PIN_W-1:0] output_level_register,
  // Asynchronous sources
  input wire logic internal_rc_oscillator,
  input wire logic secondary_oscillator_input,
  input wire logic cal_alarm,
  input wire logic ulp_wake,
  input wire logic int0_wake,
  input wire logic fault_detect,
  input wire logic bor_arm_level,
  input wire logic bor_trip_level,
  input wire logic core_brownout,
  // Power and mode outputs
  output logic deep_sleep_active,
  output logic normal_sleep_pulse,
  output logic por_reset,
  output logic calendar_clock_select,
  output logic ulp_module_power,
  output logic bor_monitor_on,
  // Pins
  output logic [PIN_W-1:0] pin_out,
  output logic [PIN_W-1:0] pin_oe
);

  localparam int PCW = $clog2(POR_CYCLES + 1);
  localparam logic [PCW-1:0] POR_LAST = PCW'(POR_CYCLES - 1);

  // Synchronisers; stage one is read only by stage two
  dsc_pkg::dsc_async_t async_in;
  dsc_pkg::dsc_async_t sync1_r;
  dsc_pkg::dsc_async_t sync2_r;
  dsc_pkg::dsc_async_t sync3_r;

  dsc_pkg::dsc_state_t state_r;
  dsc_pkg::dsc_state_t state_nxt;
  dsc_pkg::dsc_config_t cfg_r;
  logic [PCW-1:0] por_cnt_r;

  logic deep_sleep_enable_r;
  logic [1:0] deep_sleep_enable_cnt_r;
  logic ulp_mod_en_r;
  logic cal_wake_dis_r;
  logic ulp_dis_r;
  logic bor_evt_r;
  logic release_r;
  logic [7:0] scratch_r;
  logic [7:0] wake_lo_r;
  logic int0_flag_r;
  logic exit_flag_r;
  logic wdt_expire;

  assign async_in = '{
    rc_tick: internal_rc_oscillator,
    sosc_tick: secondary_oscillator_input,
    cal_alarm: cal_alarm,
    ulp_wake: ulp_wake,
    int0_wake: int0_wake,
    fault: fault_detect,
    bor_arm: bor_arm_level,
    bor_trip: bor_trip_level,
    core_bor: core_brownout
  };

  // Address decode
  wire sel_wake_lo = reg_addr == `DSC_OFS_WAKE_LO;
  wire sel_wake_hi = reg_addr == `DSC_OFS_WAKE_HI;
  wire sel_ctrl_lo = reg_addr == `DSC_OFS_CTRL_LO;
  wire sel_ctrl_hi = reg_addr == `DSC_OFS_CTRL_HI;
  wire sel_scratch = reg_addr == `DSC_OFS_SCRATCH;
  wire sel_exit = reg_addr == `DSC_OFS_EXIT;
  wire sel_config = reg_addr == `DSC_OFS_CONFIG;
  wire wr_ctrl_lo = reg_wr && sel_ctrl_lo;
  wire wr_ctrl_hi = reg_wr && sel_ctrl_hi;
  wire wr_scratch = reg_wr && sel_scratch;
  wire wr_exit = reg_wr && sel_exit;
  wire wr_config = reg_wr && sel_config;

  // Oscillator edges, from the settled stages only
  wire rc_tick = sync2_r.rc_tick && !sync3_r.rc_tick;
  wire sosc_tick = sync2_r.sosc_tick && !sync3_r.sosc_tick;

  wire in_run = state_r == dsc_pkg::DSC_ST_RUN;
  wire in_deep = state_r == dsc_pkg::DSC_ST_DEEP;
  wire in_por = state_r == dsc_pkg::DSC_ST_POR;

  // Entry needs the enable still alive on the sleep command
  wire deep_req = deep_sleep_enable_r && regulator_off_in_sleep && !idle_on_sleep_select; // [R8] [R10]
  wire enter_deep = in_run && sleep_cmd && deep_req; // [R15]
  wire enter_plain = in_run && sleep_cmd && !deep_req; // [R15]

  // Wake sources, watched only while fully in deep sleep
  wire wk_fault = in_deep && sync2_r.fault; // [R13] [R14]
  wire wk_cal = in_deep && sync2_r.cal_alarm && !cal_wake_dis_r; // [R6] [R18]
  wire wk_ulp = in_deep && sync2_r.ulp_wake && !ulp_dis_r && ulp_mod_en_r; // [R19]
  wire wk_int0 = in_deep && sync2_r.int0_wake;
  wire wk_trip = in_deep && cfg_r.bor_en && sync2_r.bor_trip; // [R5]
  wire wk_wdt = in_deep && wdt_expire; // [R26]
  wire wake_any = wk_fault || wk_cal || wk_ulp || wk_int0 || wk_trip || wk_wdt;
  wire por_entry = in_deep && wake_any; // [R11]
  wire bor_armed = in_deep && cfg_r.bor_en && sync2_r.bor_arm && !sync2_r.bor_trip; // [R20]

  // One record per wake; simultaneous sources resolved by priority
  wire [7:0] wake_rec = wk_fault ? 8'h80 :
                        wk_trip ? 8'h01 :
                        wk_wdt ? 8'h10 :
                        wk_cal ? 8'h08 :
                        wk_ulp ? 8'h20 : 8'h00; // [R25]
  wire int0_rec = wk_int0 && (wake_rec == 8'h00); // [R25]

  wire scratch_loss = wk_trip || (in_run && sync2_r.core_bor); // [R22]

  // Read mux; unimplemented bits and unmapped addresses read zero
  wire [7:0] rd_ctrl_hi = {deep_sleep_enable_r, 5'h00, ulp_mod_en_r, cal_wake_dis_r}; // [R16]
  wire [7:0] rd_ctrl_lo = {5'h00, ulp_dis_r, bor_evt_r, release_r};
  wire [7:0] rd_mux = sel_wake_lo ? wake_lo_r :
                      sel_wake_hi ? {7'h00, int0_flag_r} :
                      sel_ctrl_lo ? rd_ctrl_lo :
                      sel_ctrl_hi ? rd_ctrl_hi :
                      sel_scratch ? scratch_r :
                      sel_exit ? {4'h0, exit_flag_r, 3'h0} :
                      sel_config ? cfg_r : `DSC_RST_BYTE;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dsc_pkg::DSC_ST_RUN: begin
        if (enter_deep) begin
          state_nxt = dsc_pkg::DSC_ST_DEEP;
        end
      end
      dsc_pkg::DSC_ST_DEEP: begin
        if (wake_any) begin
          state_nxt = dsc_pkg::DSC_ST_POR; // [R11]
        end
      end
      dsc_pkg::DSC_ST_POR: begin
        if (por_cnt_r == POR_LAST) begin
          state_nxt = dsc_pkg::DSC_ST_RUN;
        end
      end
      default: begin
        state_nxt = dsc_pkg::DSC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= dsc_pkg::DSC_ST_RUN;
      por_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      por_cnt_r <= in_por ? por_cnt_r + 1'b1 : '0;
    end
  end

  // Enable lives two cycles so only a sleep command in the two cycles after the write sees it
  always_ff @(posedge sys_clk) begin
    if (reset || por_entry) begin
      deep_sleep_enable_r <= 1'b0;
      deep_sleep_enable_cnt_r <= '0;
    end else if (wr_ctrl_hi) begin
      deep_sleep_enable_r <= reg_wdata[`DSC_HI_DEEP_SLEEP_ENABLE];
      deep_sleep_enable_cnt_r <= `DSC_DEEP_SLEEP_ENABLE_LIFE;
    end else if (deep_sleep_enable_r) begin
      deep_sleep_enable_cnt_r <= deep_sleep_enable_cnt_r - 1'b1;
      deep_sleep_enable_r <= deep_sleep_enable_cnt_r != 2'h1; // [R23]
    end
  end

  // Power-on reset after wake restores the control fields
  always_ff @(posedge sys_clk) begin
    if (reset || por_entry) begin
      ulp_mod_en_r <= 1'b0;
      cal_wake_dis_r <= 1'b0;
      ulp_dis_r <= 1'b0;
    end else begin
      if (wr_ctrl_hi) begin
        ulp_mod_en_r <= reg_wdata[`DSC_HI_ULP_MOD_EN]; // [R17]
        cal_wake_dis_r <= reg_wdata[`DSC_HI_CAL_WAKE_DIS]; // [R18]
      end
      if (wr_ctrl_lo) begin
        ulp_dis_r <= reg_wdata[`DSC_LO_ULP_DIS]; // [R19]
      end
    end
  end

  // Release: a trip frees the pins at once, otherwise software must
  always_ff @(posedge sys_clk) begin
    if (reset || wk_trip) begin
      release_r <= 1'b0;
    end else if (enter_deep) begin
      release_r <= 1'b1; // [R21]
    end else if (wr_ctrl_lo && !reg_wdata[`DSC_LO_RELEASE]) begin
      release_r <= 1'b0; // [R21]
    end
  end

  // Status set by hardware wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset || enter_deep || wk_trip) begin
      bor_evt_r <= 1'b0;
    end else if (bor_armed) begin
      bor_evt_r <= 1'b1; // [R20]
    end else if (wr_ctrl_lo && !reg_wdata[`DSC_LO_BOR_EVT]) begin
      bor_evt_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || enter_deep) begin
      wake_lo_r <= 8'h00; // [R24]
      int0_flag_r <= 1'b0; // [R24]
    end else if (por_entry) begin
      wake_lo_r <= wake_rec; // [R13] [R25]
      int0_flag_r <= int0_rec;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      exit_flag_r <= 1'b0;
    end else if (por_entry) begin
      exit_flag_r <= 1'b1; // [R12]
    end else if (wr_exit && !reg_wdata[`DSC_EXIT_FLAG]) begin
      exit_flag_r <= 1'b0; // [R12]
    end
  end

  // Scratch keeps its value across deep sleep and the wake reset, except when a brown-out trip causes the wake
  always_ff @(posedge sys_clk) begin
    if (reset || scratch_loss) begin
      scratch_r <= `DSC_RST_BYTE; // [R22]
    end else if (wr_scratch) begin
      scratch_r <= reg_wdata;
    end
  end

  // Configuration is frozen outside run so sleep settings cannot drift
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_r <= `DSC_CFG_RESET;
    end else if (wr_config && in_run) begin
      cfg_r <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= `DSC_RST_BYTE;
      deep_sleep_active <= 1'b0;
      normal_sleep_pulse <= 1'b0;
      por_reset <= 1'b0;
      calendar_clock_select <= 1'b0;
      ulp_module_power <= 1'b0;
      bor_monitor_on <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : `DSC_RST_BYTE;
      deep_sleep_active <= state_nxt == dsc_pkg::DSC_ST_DEEP;
      normal_sleep_pulse <= enter_plain; // [R15]
      por_reset <= state_nxt == dsc_pkg::DSC_ST_POR; // [R11]
      calendar_clock_select <= cfg_r.cal_clk_sel; // [R7]
      ulp_module_power <= ulp_mod_en_r && (state_nxt == dsc_pkg::DSC_ST_DEEP); // [R17]
      bor_monitor_on <= cfg_r.bor_en && (state_nxt == dsc_pkg::DSC_ST_DEEP); // [R5]
    end
  end

  dsc_wdt u_wdt (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(enter_deep), // [R4]
    .run(in_deep && cfg_r.wdt_en), // [R4] [R26]
    .clk_sel(cfg_r.wdt_clk_sel), // [R2]
    .postscale(cfg_r.wdt_postscale), // [R1]
    .rc_tick(rc_tick),
    .sosc_tick(sosc_tick), // [R3]
    .expire(wdt_expire)
  );

  dsc_pin_hold #(
    .PIN_W(PIN_W)
  ) u_pins (
    .sys_clk(sys_clk),
    .reset(reset),
    .capture(enter_deep),
    .hold(release_r),
    .dir(pin_direction_register),
    .lat(output_level_register),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  a_deep_sleep_enable_self_clear: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(deep_sleep_enable_r) && !wr_ctrl_hi ##1 !wr_ctrl_hi && !por_entry |=> !deep_sleep_enable_r)
    else $error("enable did not self clear"); // [R23]
  a_entry_clears_wake: assert property (@(posedge sys_clk) disable iff (reset)
    enter_deep |=> wake_lo_r == 8'h00 && !int0_flag_r && in_deep)
    else $error("wake status not cleared"); // [R24]
  a_wake_gives_por: assert property (@(posedge sys_clk) disable iff (reset)
    por_entry |=> por_reset [*8] ##1 (por_reset || in_run))
    else $error("wake without power-on reset"); // [R11]
  a_exit_flag_set: assert property (@(posedge sys_clk) disable iff (reset)
    por_entry |=> exit_flag_r) else $error("exit flag not set"); // [R12]
  a_exit_flag_sticky: assert property (@(posedge sys_clk) disable iff (reset)
    exit_flag_r && !wr_exit |=> exit_flag_r) else $error("exit flag lost"); // [R12]
  a_fault_logged: assert property (@(posedge sys_clk) disable iff (reset)
    wk_fault |=> wake_lo_r == 8'h80 && in_por) else $error("fault not logged"); // [R13]
  a_cal_gate: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(wake_lo_r[`DSC_WK_CAL]) |-> !$past(cal_wake_dis_r))
    else $error("blocked alarm woke"); // [R18]
  a_ulp_gate: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(wake_lo_r[`DSC_WK_ULP]) |-> $past(ulp_mod_en_r) && !$past(ulp_dis_r))
    else $error("gated low power wake"); // [R19]
  a_single_record: assert property (@(posedge sys_clk) disable iff (reset)
    $onehot0({wake_lo_r, int0_flag_r})) else $error("two sources logged"); // [R25]
  a_ctrl_hi_zero: assert property (@(posedge sys_clk) disable iff (reset)
    reg_rd && sel_ctrl_hi |=> reg_rdata[6:2] == 5'h00)
    else $error("reserved bits read nonzero"); // [R16]
  a_plain_sleep: assert property (@(posedge sys_clk) disable iff (reset)
    in_run && sleep_cmd && !deep_sleep_enable_r |=> normal_sleep_pulse && !deep_sleep_active)
    else $error("wrong sleep kind"); // [R15]

endmodule

// *** tb/dsc_top_test.sv ***
// Self-checking bench for the deep sleep controller top.
// Assumes dsc_cfg.svh on the include path and the default POR_CYCLES.
`timescale 1ns/10ps
`include "dsc_cfg.svh"

module dsc_top_test;
  logic sys_clk;
  logic reset;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic sleep_cmd;
  logic idle_sel;
  logic rc_osc;
  logic [7:0] dir;
  logic [7:0] lat;
  // Sources: trip, arm, alarm, ulp, int0, fault
  logic [5:0] src;
  logic deep;
  logic nsp;
  logic por;
  logic cal_sel;
  logic ulp_pwr;
  logic bor_on;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic reg_off;
  logic rc_en;
  logic sosc;
  logic sosc_en;
  logic cbor;
  logic [11:0] addrs [7];
  int fail_count;
  int tests_run;

  dsc_top dut_u (
    .sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_cmd(sleep_cmd), .regulator_off_in_sleep(reg_off),
    .idle_on_sleep_select(idle_sel), .pin_direction_register(dir),
    .output_level_register(lat), .internal_rc_oscillator(rc_osc),
    .secondary_oscillator_input(sosc), .cal_alarm(src[3]), .ulp_wake(src[2]),
    .int0_wake(src[1]), .fault_detect(src[0]), .bor_arm_level(src[4]),
    .bor_trip_level(src[5]), .core_brownout(cbor), .deep_sleep_active(deep),
    .normal_sleep_pulse(nsp), .por_reset(por), .calendar_clock_select(cal_sel),
    .ulp_module_power(ulp_pwr), .bor_monitor_on(bor_on), .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // RC watchdog tick source, gated by rc_en, toggling on sys_clk falling edges
  initial begin
    rc_osc = 1'b0;
    forever #200 rc_osc = rc_en & ~rc_osc;
  end

  // Secondary tick source runs only once software has enabled it
  initial begin
    sosc = 1'b0;
    forever #150 sosc = sosc_en & ~sosc;
  end

  task automatic close_out;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  // Enable then sleep on the very next cycle
  task automatic enter(input logic [7:0] hi, input logic dp);
    wr(`DSC_OFS_CTRL_HI, hi);
    sleep_cmd <= 1'b1;
    dir <= 8'h55;
    lat <= 8'ha5;
    @(posedge sys_clk);
    sleep_cmd <= 1'b0;
    #1 chk({15'h0, nsp}, {15'h0, ~dp});
    @(posedge sys_clk);
    dir <= 8'h3c;
    lat <= 8'h5a;
    #1 chk({15'h0, deep}, {15'h0, dp});
  endtask

  task automatic run_case(input logic [7:0] hi, input logic [5:0] s, input logic blk,
                          input logic [15:0] ew, input logic [7:0] el);
    logic [7:0] wh;
    logic [7:0] wl;
    int n;
    enter(hi, 1'b1);
    rchk(`DSC_OFS_WAKE_LO, 8'h00);
    chk({15'h0, ulp_pwr}, {15'h0, hi[1]});
    chk({15'h0, bor_on}, 16'h0001);
    @(posedge sys_clk);
    src <= s;
    n = 0;
    while (por !== 1'b1 && n < 10) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk({15'h0, deep}, {15'h0, blk});
    if (blk && s != 6'h00) begin
      @(posedge sys_clk);
      src <= s | 6'h01;
    end
    n = 0;
    while (por !== 1'b1 && n < 1500) begin
      @(posedge sys_clk);
      #1 n++;
    end
    n = 0;
    while (por === 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(16'(n), 16'(`DSC_POR_CYCLES));
    chk({pin_out, pin_oe}, s[5] ? 16'h5ac3 : 16'ha5aa);
    @(posedge sys_clk);
    src <= 6'h00;
    rd(`DSC_OFS_WAKE_HI, wh);
    rd(`DSC_OFS_WAKE_LO, wl);
    chk({wh, wl}, ew);
    rchk(`DSC_OFS_EXIT, 8'h08);
    rchk(`DSC_OFS_CTRL_LO, el);
    rchk(`DSC_OFS_SCRATCH, s[5] ? 8'h00 : 8'h5a);
    wr(`DSC_OFS_EXIT, 8'h00);
    wr(`DSC_OFS_CTRL_LO, 8'h00);
    dir <= 8'h0f;
    rchk(`DSC_OFS_EXIT, 8'h00);
    chk({pin_out, pin_oe}, 16'h5af0);
  endtask

  initial begin
    reset = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_cmd = 1'b0;
    idle_sel = 1'b0;
    dir = 8'h0f;
    lat = 8'ha5;
    src = 6'h00;
    reg_off = 1'b1;
    rc_en = 1'b1;
    sosc_en = 1'b0;
    cbor = 1'b0;
    fail_count = 0;
    tests_run = 0;
    addrs = '{12'hf4a, 12'hf4b, 12'hf4c, 12'hf4d, 12'hf4f, 12'hf50, 12'hf51};
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (addrs[i]) rchk(addrs[i], 8'h00);
    // Late sleep after the enable has lapsed falls back to ordinary sleep
    wr(`DSC_OFS_CTRL_HI, 8'hff);
    repeat (3) @(posedge sys_clk);
    sleep_cmd <= 1'b1;
    @(posedge sys_clk);
    sleep_cmd <= 1'b0;
    #1 chk({15'h0, nsp}, 16'h0001);
    rchk(`DSC_OFS_CTRL_HI, 8'h03);
    @(posedge sys_clk);
    idle_sel <= 1'b1;
    enter(8'h80, 1'b0);
    @(posedge sys_clk);
    idle_sel <= 1'b0;
    reg_off <= 1'b0;
    enter(8'h80, 1'b0);
    @(posedge sys_clk);
    reg_off <= 1'b1;
    dir <= 8'h0f;
    wr(`DSC_OFS_CTRL_HI, 8'h00);
    wr(`DSC_OFS_SCRATCH, 8'h5a);
    wr(`DSC_OFS_CONFIG, 8'h0d);
    rchk(`DSC_OFS_CONFIG, 8'h0d);
    chk({15'h0, cal_sel}, 16'h0001);
    run_case(8'h80, 6'h08, 1'b0, 16'h0008, 8'h01);
    run_case(8'h81, 6'h08, 1'b1, 16'h0080, 8'h01);
    run_case(8'h82, 6'h04, 1'b0, 16'h0020, 8'h01);
    run_case(8'h80, 6'h04, 1'b1, 16'h0080, 8'h01);
    run_case(8'h80, 6'h02, 1'b0, 16'h0100, 8'h01);
    run_case(8'h82, 6'h0c, 1'b0, 16'h0008, 8'h01);
    run_case(8'h80, 6'h00, 1'b1, 16'h0010, 8'h01);
    run_case(8'h80, 6'h10, 1'b1, 16'h0080, 8'h03);
    // Only the secondary source ticks now, so a wake proves the select
    wr(`DSC_OFS_CONFIG, 8'h0f);
    rc_en <= 1'b0;
    sosc_en <= 1'b1;
    run_case(8'h80, 6'h00, 1'b1, 16'h0010, 8'h01);
    run_case(8'h80, 6'h30, 1'b0, 16'h0001, 8'h00);
    // Core brown-out in run wipes the scratch byte two syncs later
    wr(`DSC_OFS_SCRATCH, 8'h3c);
    cbor <= 1'b1;
    rchk(`DSC_OFS_SCRATCH, 8'h3c);
    rchk(`DSC_OFS_SCRATCH, 8'h00);
    close_out;
  end

  initial begin
    #(20000 * 50);
    fail_count++;
    close_out;
  end
endmodule
